/* File: design/afec_cfg.svh */
`ifndef AFEC_CFG_SVH
`define AFEC_CFG_SVH

// ==========================================
// Framing bytes
`define AFEC_START       8'h7E
`define AFEC_ESC         8'h7D
`define AFEC_ESC_MASK    8'h20
`define AFEC_XON         8'h11
`define AFEC_XOFF        8'h13
`define AFEC_CKS_GOOD    8'hFF
`define AFEC_ZERO8       8'h00

// ==========================================
// Frame types and field positions
`define AFEC_TYPE_TX64   8'h00
`define AFEC_TYPE_TXST   8'h89
`define AFEC_IDX_TYPE    16'h0000
`define AFEC_IDX_ID      16'h0001
`define AFEC_IDX_ADDR0   16'h0002
`define AFEC_IDX_ADDR7   16'h0009
`define AFEC_IDX_OPT     16'h000A
`define AFEC_IDX_PAY     16'h000B
`define AFEC_OPT_NOACK   0
`define AFEC_OPT_BPAN    2
`define AFEC_BCAST64     64'h000000000000FFFF
`define AFEC_TXST_LEN    16'h0003

// ==========================================
// Registers
`define AFEC_REG_CTRL    4'h0
`define AFEC_REG_STAT    4'h4
`define AFEC_REG_LAST    4'h8
`define AFEC_CTRL_RST    2'h0

`endif

/* File: design/afec_cksum.sv */
`timescale 1ns/1ps
`default_nettype none
module afec_cksum #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Accumulate
  input  wire logic         clr,
  input  wire logic         add,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] sum
);
  logic [W-1:0] sum_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sum_q <= {W{1'b0}};
    end else if (clr) begin
      sum_q <= {W{1'b0}};
    end else if (add) begin
      sum_q <= sum_q + din;
    end
  end

  assign sum = sum_q;
endmodule
`default_nettype wire

/* File: design/afec_pkg.sv */
package afec_pkg;
  typedef logic [1:0] afec_mode_t;
  localparam afec_mode_t MODE_TRANSP = 2'h0;
  localparam afec_mode_t MODE_API    = 2'h1;
  localparam afec_mode_t MODE_ESC    = 2'h2;

  typedef enum logic [2:0] {
    RX_HUNT, RX_LEN_H, RX_LEN_L, RX_DATA, RX_CKS
  } afec_rx_st_e;

  typedef enum logic [2:0] {
    TS_IDLE, TS_DELIM, TS_LEN_H, TS_LEN_L, TS_TYPE, TS_ID, TS_STAT, TS_CKS
  } afec_ts_st_e;
endpackage

/* File: design/afec_top.sv */
// Function
// - Unescaped delimiter in escaped mode restarts frame
// - Escape as marker byte then byte XOR mask
// - Escape delimiter, escape, XON and XOFF
// - Length MSB first, then data, then checksum
// - Length counts frame data bytes only
// - First data byte is the frame type
// - Checksum is all-ones minus low sum byte
// - Accept when data plus checksum sums all-ones
// - Failed checksum frames cause no action; here their payload bytes still go out on rf_pay_byte, then rf_pay_drop pulses
// - Length and checksum use unescaped values
// - Status frame echoes id, none for zero
// - Eight byte destination MSB first, broadcast value
// - Options bits: no acknowledge, broadcast network
// - Bytes before delimiter and bad frames dropped
// - Escaped mode only on the UART port
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "afec_cfg.svh"
module afec_top #(
  parameter int unsigned MAX_PAYLOAD = 110
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Port kind
  input  wire logic        port_is_uart,
  // Serial receive bytes
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  // Serial transmit bytes
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // Radio request
  output logic             rf_req,
  output logic      [63:0] rf_dest,
  output logic      [7:0]  rf_frame_id,
  output logic             rf_no_ack,
  output logic             rf_bcast_pan,
  output logic             rf_bcast,
  output logic      [7:0]  rf_pay_byte,
  output logic             rf_pay_valid,
  output logic             rf_pay_drop,
  // Radio completion
  input  wire logic        rf_done,
  input  wire logic [7:0]  rf_status
);
  import afec_pkg::*;

  localparam logic [15:0] MAX_PAY16 = 16'(MAX_PAYLOAD);

  // ==========================================
  // Mode control
  afec_mode_t mode_q;
  logic       structured;
  logic       esc_en;

  assign structured = (mode_q == MODE_API) || (mode_q == MODE_ESC);
  assign esc_en = (mode_q == MODE_ESC) && port_is_uart;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `AFEC_CTRL_RST;
    end else if (reg_wr && reg_addr == `AFEC_REG_CTRL &&
                 reg_wdata[1:0] != 2'h3) begin
      mode_q <= reg_wdata[1:0];
    end
  end

  // ==========================================
  // Receive byte classification
  afec_rx_st_e rx_st_q;
  logic        esc_q;
  logic        rx_restart;
  logic        rx_mark;
  logic        rx_take;
  logic [7:0]  rx_val;
  logic        rx_dat;
  logic        rx_end;
  logic [7:0]  rx_sum;
  logic [7:0]  rx_total;
  logic        rx_ok;

  // In escaped mode any raw delimiter restarts; otherwise only while hunting
  assign rx_restart = structured && rx_valid && rx_byte == `AFEC_START &&
                      (esc_en || rx_st_q == RX_HUNT);
  assign rx_mark = esc_en && rx_valid && rx_byte == `AFEC_ESC &&
                   !rx_restart;
  assign rx_take = structured && rx_valid && !rx_restart && !rx_mark;
  assign rx_val = esc_q ? (rx_byte ^ `AFEC_ESC_MASK) : rx_byte;
  assign rx_dat = rx_take && rx_st_q == RX_DATA;
  assign rx_end = rx_take && rx_st_q == RX_CKS;
  assign rx_total = rx_sum + rx_val;
  assign rx_ok = rx_total == `AFEC_CKS_GOOD;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      esc_q <= 1'b0;
    end else if (rx_restart || rx_take) begin
      esc_q <= 1'b0;
    end else if (rx_mark) begin
      esc_q <= 1'b1;
    end
  end

  // ==========================================
  // Frame delimiting
  logic [15:0] len_q;
  logic [15:0] idx_q;
  logic        rx_abort;

  // A frame cut short by a new delimiter or an empty length is lost
  assign rx_abort = (rx_restart && rx_st_q != RX_HUNT) ||
                    (rx_take && rx_st_q == RX_LEN_L &&
                     {len_q[15:8], rx_val} == 16'h0000);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_q <= RX_HUNT;
      len_q   <= 16'h0000;
      idx_q   <= 16'h0000;
    end else if (!structured) begin
      rx_st_q <= RX_HUNT;
    end else if (rx_restart) begin
      rx_st_q <= RX_LEN_H;
    end else if (rx_take) begin
      case (rx_st_q)
        RX_HUNT: begin
          rx_st_q <= RX_HUNT;
        end
        RX_LEN_H: begin
          len_q[15:8] <= rx_val;
          rx_st_q     <= RX_LEN_L;
        end
        RX_LEN_L: begin
          len_q[7:0] <= rx_val;
          idx_q      <= 16'h0000;
          if ({len_q[15:8], rx_val} == 16'h0000) begin
            rx_st_q <= RX_HUNT;
          end else begin
            rx_st_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          idx_q <= idx_q + 16'h0001;
          if (idx_q == len_q - 16'h0001) begin
            rx_st_q <= RX_CKS;
          end
        end
        RX_CKS: begin
          rx_st_q <= RX_HUNT;
        end
        default: begin
          rx_st_q <= RX_HUNT;
        end
      endcase
    end
  end

  afec_cksum #(
    .W (8)
  ) u_rx_cksum (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (rx_restart),
    .add      (rx_dat),
    .din      (rx_val),
    .sum      (rx_sum)
  );

  // ==========================================
  // Transmit request field capture
  logic [7:0]  type_q;
  logic [7:0]  id_q;
  logic [63:0] addr_q;
  logic [7:0]  opt_q;
  logic        over_q;
  logic        pay_open_q;
  logic        is_tx64;
  logic        rx_good;
  logic        in_pay;

  assign is_tx64 = type_q == `AFEC_TYPE_TX64;
  assign in_pay = rx_dat && idx_q >= `AFEC_IDX_PAY && is_tx64;
  assign rx_good = rx_end && rx_ok && is_tx64 && !over_q &&
                   len_q >= `AFEC_IDX_PAY;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      type_q <= 8'hFF;
      id_q   <= 8'h00;
      addr_q <= 64'h0000000000000000;
      opt_q  <= 8'h00;
      over_q <= 1'b0;
    end else if (rx_restart) begin
      over_q <= 1'b0;
    end else if (rx_dat) begin
      if (idx_q == `AFEC_IDX_TYPE) begin
        type_q <= rx_val;
      end else if (idx_q == `AFEC_IDX_ID) begin
        id_q <= rx_val;
      end else if (idx_q >= `AFEC_IDX_ADDR0 && idx_q <= `AFEC_IDX_ADDR7) begin
        addr_q <= {addr_q[55:0], rx_val};
      end else if (idx_q == `AFEC_IDX_OPT) begin
        opt_q <= rx_val;
      end else if (in_pay && idx_q >= `AFEC_IDX_PAY + MAX_PAY16) begin
        over_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // Radio side outputs
  logic        rf_req_q;
  logic [63:0] rf_dest_q;
  logic [7:0]  rf_id_q;
  logic [7:0]  rf_opt_q;
  logic [7:0]  pay_q;
  logic        pay_v_q;
  logic        drop_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pay_q      <= 8'h00;
      pay_v_q    <= 1'b0;
      pay_open_q <= 1'b0;
      drop_q     <= 1'b0;
    end else begin
      pay_v_q <= 1'b0;
      drop_q  <= 1'b0;
      if (mode_q == MODE_TRANSP && rx_valid) begin
        pay_q   <= rx_byte;
        pay_v_q <= 1'b1;
      end else if (in_pay && !over_q &&
                   idx_q < `AFEC_IDX_PAY + MAX_PAY16) begin
        pay_q      <= rx_val;
        pay_v_q    <= 1'b1;
        pay_open_q <= 1'b1;
      end
      if (pay_open_q && ((rx_end && !rx_good) || rx_restart)) begin
        drop_q     <= 1'b1;
        pay_open_q <= 1'b0;
      end else if (rx_good) begin
        pay_open_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rf_req_q  <= 1'b0;
      rf_dest_q <= 64'h0000000000000000;
      rf_id_q   <= 8'h00;
      rf_opt_q  <= 8'h00;
    end else begin
      rf_req_q <= rx_good;
      if (rx_good) begin
        rf_dest_q <= addr_q;
        rf_id_q   <= id_q;
        rf_opt_q  <= opt_q;
      end
    end
  end

  assign rf_req       = rf_req_q;
  assign rf_dest      = rf_dest_q;
  assign rf_frame_id  = rf_id_q;
  assign rf_no_ack    = rf_opt_q[`AFEC_OPT_NOACK];
  assign rf_bcast_pan = rf_opt_q[`AFEC_OPT_BPAN];
  assign rf_bcast     = rf_dest_q == `AFEC_BCAST64;
  assign rf_pay_byte  = pay_q;
  assign rf_pay_valid = pay_v_q;
  assign rf_pay_drop  = drop_q;

  // ==========================================
  // Transmit status frame
  afec_ts_st_e ts_st_q;
  logic        pend_q;
  logic [7:0]  pend_id_q;
  logic [7:0]  stat_q;
  logic [7:0]  ts_sum;
  logic        ts_adv;
  logic        ts_add;
  afec_tx_if   tif ();

  assign ts_adv = tif.valid && tif.ready;
  assign ts_add = ts_adv &&
                  (ts_st_q == TS_TYPE || ts_st_q == TS_ID ||
                   ts_st_q == TS_STAT);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_q    <= 1'b0;
      pend_id_q <= 8'h00;
    end else if (rf_req_q) begin
      pend_q    <= 1'b1;
      pend_id_q <= rf_id_q;
    end else if (rf_done) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ts_st_q <= TS_IDLE;
      stat_q  <= 8'h00;
    end else if (ts_st_q == TS_IDLE) begin
      if (rf_done && pend_q && pend_id_q != `AFEC_ZERO8 && structured) begin
        stat_q  <= rf_status;
        ts_st_q <= TS_DELIM;
      end
    end else if (ts_adv) begin
      case (ts_st_q)
        TS_DELIM: ts_st_q <= TS_LEN_H;
        TS_LEN_H: ts_st_q <= TS_LEN_L;
        TS_LEN_L: ts_st_q <= TS_TYPE;
        TS_TYPE:  ts_st_q <= TS_ID;
        TS_ID:    ts_st_q <= TS_STAT;
        TS_STAT:  ts_st_q <= TS_CKS;
        TS_CKS:   ts_st_q <= TS_IDLE;
        default:  ts_st_q <= TS_IDLE;
      endcase
    end
  end

  always_comb begin
    tif.dat = `AFEC_ZERO8;
    tif.raw = 1'b0;
    case (ts_st_q)
      TS_DELIM: begin
        tif.dat = `AFEC_START;
        tif.raw = 1'b1;
      end
      TS_LEN_H: tif.dat = 8'(`AFEC_TXST_LEN >> 8);
      TS_LEN_L: tif.dat = 8'(`AFEC_TXST_LEN);
      TS_TYPE:  tif.dat = `AFEC_TYPE_TXST;
      TS_ID:    tif.dat = pend_id_q;
      TS_STAT:  tif.dat = stat_q;
      TS_CKS:   tif.dat = `AFEC_CKS_GOOD - ts_sum;
      default:  tif.dat = `AFEC_ZERO8;
    endcase
  end

  assign tif.valid  = ts_st_q != TS_IDLE;
  assign tif.esc_en = esc_en;

  afec_cksum #(
    .W (8)
  ) u_ts_cksum (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clr      (ts_st_q == TS_DELIM),
    .add      (ts_add),
    .din      (tif.dat),
    .sum      (ts_sum)
  );

  afec_tx_enc u_tx_enc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .src      (tif),
    .tx_byte  (tx_byte),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready)
  );

  // ==========================================
  // Frame counters
  logic [15:0] good_cnt_q;
  logic [15:0] bad_cnt_q;
  logic        cnt_clr;
  logic        bad_evt;

  assign cnt_clr = reg_wr && reg_addr == `AFEC_REG_STAT;
  assign bad_evt = (rx_end && !rx_ok) || rx_abort;

  // A frame event in the clearing cycle still counts
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      good_cnt_q <= 16'h0000;
      bad_cnt_q  <= 16'h0000;
    end else begin
      if (rx_end && rx_ok) begin
        good_cnt_q <= (cnt_clr ? 16'h0000 : good_cnt_q) + 16'h0001;
      end else if (cnt_clr) begin
        good_cnt_q <= 16'h0000;
      end
      if (bad_evt) begin
        bad_cnt_q <= (cnt_clr ? 16'h0000 : bad_cnt_q) + 16'h0001;
      end else if (cnt_clr) begin
        bad_cnt_q <= 16'h0000;
      end
    end
  end

  // ==========================================
  // Register read
  logic [31:0] rdata_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `AFEC_REG_CTRL: rdata_q <= {30'h00000000, mode_q};
        `AFEC_REG_STAT: rdata_q <= {bad_cnt_q, good_cnt_q};
        `AFEC_REG_LAST: rdata_q <= {14'h0000, ts_st_q != TS_IDLE, pend_q,
                                    id_q, type_q};
        default:        rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

/* File: design/afec_tx_enc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "afec_cfg.svh"
module afec_tx_enc (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Unescaped bytes
  afec_tx_if.enc          src,
  // Serial side
  output logic      [7:0] tx_byte,
  output logic            tx_valid,
  input  wire logic       tx_ready
);
  logic [7:0] out_q;
  logic [7:0] hold_q;
  logic       out_v_q;
  logic       hold_v_q;
  logic       need_esc;
  logic       take;

  assign need_esc = src.esc_en && !src.raw &&
                    (src.dat == `AFEC_START || src.dat == `AFEC_ESC ||
                     src.dat == `AFEC_XON || src.dat == `AFEC_XOFF);
  assign src.ready = !hold_v_q && (!out_v_q || tx_ready);
  assign take = src.valid && src.ready;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_q    <= 8'h00;
      hold_q   <= 8'h00;
      out_v_q  <= 1'b0;
      hold_v_q <= 1'b0;
    end else if (take) begin
      out_q    <= need_esc ? `AFEC_ESC : src.dat;
      out_v_q  <= 1'b1;
      hold_q   <= src.dat ^ `AFEC_ESC_MASK;
      hold_v_q <= need_esc;
    end else if (hold_v_q && (!out_v_q || tx_ready)) begin
      out_q    <= hold_q;
      out_v_q  <= 1'b1;
      hold_v_q <= 1'b0;
    end else if (tx_ready) begin
      out_v_q  <= 1'b0;
    end
  end

  assign tx_byte  = out_q;
  assign tx_valid = out_v_q;
endmodule
`default_nettype wire

/* File: design/afec_tx_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface afec_tx_if;
  logic [7:0] dat;
  logic       raw;
  logic       valid;
  logic       ready;
  logic       esc_en;

  modport src (output dat, output raw, output valid, output esc_en,
               input ready);
  modport enc (input dat, input raw, input valid, input esc_en,
               output ready);
endinterface
`default_nettype wire

/* File: dv/afec_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module afec_host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Stall control
  input  wire logic       slow,
  // Serial bytes
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            tx_ready
);
  int seed_h = 32'hc5d3;

  initial begin
    rx_byte  = 8'hA5;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // Host takes bytes at will, stalling at random when slow
  always @(posedge core_clk) begin
    tx_ready <= resetn && (!slow || ($random(seed_h) % 4 != 0));
  end

  task automatic put_byte(input logic [7:0] b);
    @(posedge core_clk);
    rx_byte  <= b;
    rx_valid <= 1'b1;
  endtask

  // Idle line keeps toggling so stale data never looks valid
  task automatic rest(input int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_byte  <= ~rx_byte;
    end
  endtask

  task automatic put_esc(input logic [7:0] b, input logic esc);
    if (esc && (b inside {8'h7E, 8'h7D, 8'h11, 8'h13})) begin
      put_byte(8'h7D);
      put_byte(b ^ 8'h20);
    end else begin
      put_byte(b);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/afec_props.sv */
`timescale 1ns/1ps
`default_nettype none
module afec_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Serial side
  input wire logic        port_is_uart,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_valid,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  // Radio side
  input wire logic        rf_req,
  input wire logic [63:0] rf_dest,
  input wire logic        rf_bcast,
  input wire logic [7:0]  rf_pay_byte,
  input wire logic        rf_pay_valid,
  input wire logic        rf_pay_drop
);
  logic [1:0] mode_q;
  logic       esc_on;

  // ==========================================
  // Mode shadow from register writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= 2'h0;
    end else if (reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] != 2'h3) begin
      mode_q <= reg_wdata[1:0];
    end
  end
  assign esc_on = (mode_q == 2'h2) && port_is_uart;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ==========================================
  // Properties
  sequence s_esc_mark;
    esc_on && tx_valid && tx_ready && tx_byte == 8'h7D;
  endsequence
  sequence s_esc_tail;
    tx_valid && (tx_byte inside {8'h5E, 8'h5D, 8'h31, 8'h33});
  endsequence
  property p_esc_pair;
    s_esc_mark |=> s_esc_tail;
  endproperty
  property p_no_raw;
    esc_on && tx_valid |-> tx_byte != 8'h11 && tx_byte != 8'h13;
  endproperty
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
  endproperty
  property p_start;
    $rose(tx_valid) |-> tx_byte == 8'h7E;
  endproperty
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  property p_req_cause;
    rf_req |-> $past(rx_valid) && !rf_pay_drop;
  endproperty
  property p_bcast;
    rf_bcast == (rf_dest == 64'h000000000000FFFF);
  endproperty
  property p_transp;
    mode_q == 2'h0 && rx_valid |=> rf_pay_valid && !tx_valid
      && rf_pay_byte == $past(rx_byte);
  endproperty

  a_esc_pair: assert property (p_esc_pair)
    else $error("escape byte not followed by masked byte");
  a_no_raw: assert property (p_no_raw)
    else $error("flow control byte sent unescaped");
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit byte changed while stalled");
  a_start: assert property (p_start)
    else $error("transmit frame not opened by delimiter");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
  a_req_cause: assert property (p_req_cause)
    else $error("request not tied to checksum byte");
  a_bcast: assert property (p_bcast)
    else $error("broadcast flag disagrees with address");
  a_transp: assert property (p_transp)
    else $error("transparent byte not passed through");
endmodule

bind afec_top afec_props u_afec_props (
  .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .port_is_uart, .rx_byte, .rx_valid, .tx_byte,
  .tx_valid, .tx_ready, .rf_req, .rf_dest, .rf_bcast, .rf_pay_byte,
  .rf_pay_valid, .rf_pay_drop
);
`default_nettype wire

/* File: dv/api_frame_escape_checksum_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module api_frame_escape_checksum_tb_top;
  logic        core_clk = 1'b0;
  logic        resetn, reg_wr, reg_rd, port_is_uart, slow;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0]  rx_byte, tx_byte, rf_frame_id, rf_pay_byte, rf_status, b;
  logic        rx_valid, tx_valid, tx_ready, rf_req, rf_no_ack;
  logic        rf_bcast_pan, rf_bcast, rf_pay_valid, rf_pay_drop, rf_done;
  logic [63:0] rf_dest;
  logic [7:0]  q_pay[$], q_tx[$];
  logic [75:0] q_rf[$], q_rd[$];
  logic        rd_pend = 1'b0;
  int          errors = 0, checks_done = 0, seed = 32'hc5d3;
  // Small payload limit so the oversize path is reachable
  localparam int MAXP = 4;

  always #5 core_clk = ~core_clk;

  afec_top #(.MAX_PAYLOAD(MAXP)) u_afec_top (.core_clk, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_is_uart,
    .rx_byte, .rx_valid, .tx_byte,
    .tx_valid, .tx_ready, .rf_req, .rf_dest, .rf_frame_id, .rf_no_ack,
    .rf_bcast_pan, .rf_bcast, .rf_pay_byte, .rf_pay_valid, .rf_pay_drop,
    .rf_done, .rf_status);
  afec_host_model u_afec_host_model (.core_clk, .resetn, .slow, .rx_byte,
    .rx_valid, .tx_ready);

  // ==========================================
  // Compare and report
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkw(string nm, logic [75:0] e, logic [75:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    rd_pend <= reg_rd;
    if (rd_pend) chkw("reg_rdata", q_rd.pop_front(), 76'(reg_rdata));
    if (rf_pay_valid) chk8("pay", q_pay.pop_front(), rf_pay_byte);
    if (rf_req || rf_pay_drop) chkw("rf_event", q_rf.pop_front(),
      rf_pay_drop ? {1'b1, 75'h0} : {1'b0, rf_no_ack, rf_bcast_pan,
      rf_bcast, rf_frame_id, rf_dest});
    if (tx_valid && tx_ready) chk8("tx", q_tx.pop_front(), tx_byte);
  end

  // ==========================================
  // Drivers
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q_rd.push_back(76'(e));
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (q_tx.size() + q_pay.size() + q_rf.size() + q_rd.size() != 0
           && n < 800) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 800) begin
      errors++;
      wrap_up();
    end
    repeat (4) @(posedge core_clk);
  endtask
  // Kind 0 good, 1 bad checksum, 2 cut before checksum
  task automatic frame(input logic [7:0] id, input logic [63:0] dst,
      input logic [7:0] opt, input int np, input int kind, input logic esc);
    logic [7:0] d[$];
    logic [7:0] s;
    d = {8'h00, id};
    for (int i = 7; i >= 0; i--) d.push_back(dst[8*i +: 8]);
    d.push_back(opt);
    for (int i = 0; i < np; i++) d.push_back(8'($random(seed)));
    s = 8'h00;
    foreach (d[i]) s += d[i];
    for (int i = 11; i < d.size() && i < 11 + MAXP; i++)
      q_pay.push_back(d[i]);
    if (kind == 0 && np <= MAXP) q_rf.push_back({1'b0, opt[0], opt[2],
      dst == 64'h000000000000FFFF, id, dst});
    else q_rf.push_back({1'b1, 75'h0});
    u_afec_host_model.put_byte(8'h7E);
    u_afec_host_model.put_esc(8'(d.size() >> 8), esc);
    u_afec_host_model.put_esc(8'(d.size()), esc);
    foreach (d[i]) u_afec_host_model.put_esc(d[i], esc);
    if (kind != 2) u_afec_host_model.put_esc(
      (kind == 0) ? 8'hFF - s : 8'hFE - s, esc);
    u_afec_host_model.rest(2);
  endtask
  task automatic status(input logic [7:0] id, input logic esc);
    logic [7:0] st;
    logic [7:0] f[$];
    st = 8'($random(seed));
    f = {8'h00, 8'h03, 8'h89, id, st, 8'hFF - 8'(8'h89 + id + st)};
    if (id != 8'h00) begin
      q_tx.push_back(8'h7E);
      foreach (f[i])
        if (esc && (f[i] inside {8'h7E, 8'h7D, 8'h11, 8'h13}))
          q_tx = {q_tx, 8'h7D, f[i] ^ 8'h20};
        else q_tx.push_back(f[i]);
    end
    @(posedge core_clk);
    rf_done   <= 1'b1;
    rf_status <= st;
    @(posedge core_clk);
    rf_done   <= 1'b0;
    drain();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    rf_done      = 1'b0;
    resetn       = 1'b0;
    reg_addr     = 4'($random(seed));
    reg_wdata    = $random(seed);
    rf_status    = 8'($random(seed));
    port_is_uart = 1'($random(seed));
    slow         = 1'($random(seed));
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h8, 32'hFF);
    rd(4'hC, 32'h0);
    wr(4'h0, 32'h3);
    rd(4'h0, 32'h0);
    for (int i = 0; i < 6; i++) begin
      b = 8'($random(seed));
      q_pay.push_back(b);
      u_afec_host_model.put_byte(b);
    end
    u_afec_host_model.rest(3);
    drain();
    wr(4'h0, 32'h1);
    wr(4'h4, 32'h0);
    slow <= 1'b1;
    u_afec_host_model.put_byte(8'h55);
    u_afec_host_model.put_byte(8'h13);
    frame(8'h05, 64'h7E11137D00000000 | 64'($unsigned($random(seed))),
          8'h05, 3, 0, 0);
    status(8'h05, 1'b0);
    frame(8'h42, 64'h0A0B0C0D0E0F1011, 8'h00, 5, 0, 0);
    frame(8'h22, 64'h0123456789ABCDEF, 8'h00, 2, 1, 0);
    drain();
    rd(4'h4, {16'd1, 16'd2});
    port_is_uart <= 1'b1;
    wr(4'h0, 32'h2);
    wr(4'h4, 32'h0);
    u_afec_host_model.put_byte(8'h7E);
    u_afec_host_model.put_byte(8'h00);
    u_afec_host_model.put_byte(8'h0C);
    frame(8'h31, 64'h1111, 8'h00, 3, 2, 1);
    frame(8'h7D, 64'h7E11137D7E000000, 8'h01, 4, 0, 1);
    status(8'h7D, 1'b1);
    frame(8'h00, 64'h000000000000FFFF, 8'h04, 1, 0, 1);
    status(8'h00, 1'b1);
    rd(4'h4, {16'd2, 16'd2});
    port_is_uart <= 1'b0;
    frame(8'h11, 64'h7E00000000000013, 8'h00, 1, 0, 0);
    status(8'h11, 1'b0);
    drain();
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
